// File: src/rso_pkg.sv
// shared constants, types and register map of the reset supervisor
package rso_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS          = 20;
    localparam int unsigned RESET_FILTER_TIME_NS   = 10_000;
    localparam int unsigned RESET_DELAY_FIRST_NS   = 10_000_000;
    localparam int unsigned RESET_DELAY_SECOND_NS  = 2_000_000;
    localparam int unsigned RESET_FILTER_CYCLES    =
        (RESET_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_DELAY_FIRST_CYC  =
        (RESET_DELAY_FIRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_DELAY_SECOND_CYC =
        (RESET_DELAY_SECOND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W                = 20;

    // ************************************************************
    // register bus and map
    // ************************************************************
    localparam int unsigned ADDR_W            = 4;
    localparam int unsigned DATA_W            = 8;
    localparam logic [3:0]  REG_CTRL_ADDR     = 4'h0;
    localparam logic [3:0]  REG_STATUS_ADDR   = 4'h1;
    localparam int unsigned CTRL_MODE_LSB     = 0;
    localparam int unsigned CTRL_SR_SEL_BIT   = 2;
    localparam int unsigned CTRL_DLY_SEL_BIT  = 3;
    localparam int unsigned CTRL_THR_LSB      = 4;
    localparam int unsigned STAT_POR_BIT      = 0;
    localparam int unsigned STAT_WD_FAIL_BIT  = 1;
    localparam int unsigned STAT_RST_LOW_BIT  = 2;
    localparam int unsigned STAT_MODE_LSB     = 3;
    localparam logic        SR_SEL_RST        = 1'h0;
    localparam logic        DLY_SEL_RST       = 1'h0;
    localparam logic [1:0]  THR_SEL_RST       = 2'h0;

    // mode field codes written by software
    localparam logic [1:0]  MODE_CODE_NORMAL  = 2'h0;
    localparam logic [1:0]  MODE_CODE_SLEEP   = 2'h1;
    localparam logic [1:0]  MODE_CODE_STOP    = 2'h2;
    localparam logic [1:0]  MODE_CODE_SOFTRST = 2'h3;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } rso_bus_req_t;

    typedef enum logic [4:0] {
        DEV_INIT    = 5'h01,
        DEV_NORMAL  = 5'h02,
        DEV_STOP    = 5'h04,
        DEV_SLEEP   = 5'h08,
        DEV_RESTART = 5'h10
    } rso_dev_mode_t;

    typedef enum logic [4:0] {
        RS_PWRUP  = 5'h01,
        RS_RUN    = 5'h02,
        RS_FILTER = 5'h04,
        RS_HOLD   = 5'h08,
        RS_DELAY  = 5'h10
    } rso_rst_state_t;

    typedef struct packed {
        logic              uv_meta;
        logic              uv_sync;
        rso_rst_state_t    fsm;
        rso_dev_mode_t     mode;
        logic              sr_sel;
        logic              dly_sel;
        logic [1:0]        thr_sel;
        logic              por_flag;
        logic              wd_fail_flag;
        logic [DATA_W-1:0] rdata;
        logic              rst_n;
        logic              drive_low;
        logic              wd_start;
    } rso_main_state_t;

    // the regulator counts as low until the synchroniser has seen it up
    localparam rso_main_state_t MAIN_RESET = '{
        uv_meta:      1'h1,
        uv_sync:      1'h1,
        fsm:          RS_PWRUP,
        mode:         DEV_INIT,
        sr_sel:       SR_SEL_RST,
        dly_sel:      DLY_SEL_RST,
        thr_sel:      THR_SEL_RST,
        por_flag:     1'h1,
        wd_fail_flag: 1'h0,
        rdata:        8'h00,
        rst_n:        1'h0,
        drive_low:    1'h1,
        wd_start:     1'h0
    };

    typedef struct packed {
        logic               busy;
        logic [TIMER_W-1:0] cnt;
        logic               done;
    } rso_timer_state_t;

endpackage

// File: src/rso_timer.sv
// one-shot down counter timing the filter and release delays
`timescale 1ns/1ps
module rso_timer #(
    parameter int unsigned CNT_W = rso_pkg::TIMER_W
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic             start_in,
    input  wire logic             abort_in,
    input  wire logic [CNT_W-1:0] len_in,
    output logic                  done_out
);
    import rso_pkg::*;

    typedef struct packed {
        logic             busy;
        logic [CNT_W-1:0] cnt;
        logic             done;
    } rso_tmr_st_t;

    rso_tmr_st_t st_q;
    rso_tmr_st_t st_d;

    // done pulses len_in edges after the start edge
    always_comb begin
        st_d      = st_q;
        st_d.done = 1'h0;
        if (start_in) begin
            st_d.busy = 1'h1;
            st_d.cnt  = len_in;
        end else if (abort_in) begin
            st_d.busy = 1'h0;
        end else if (st_q.busy) begin
            if (st_q.cnt <= CNT_W'(1)) begin
                st_d.busy = 1'h0;
                st_d.done = 1'h1;
            end else begin
                st_d.cnt = st_q.cnt - CNT_W'(1);
            end
        end
        if (!ce_in) begin
            st_d = st_q;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done_out = st_q.done;

endmodule

// File: src/rso_reset_supervisor.sv
// reset output supervisor with undervoltage filter, release delay and soft reset
//
// Operation
// - on undervoltage, reset output goes low only after the filter time with the event still present
// - output stays low while the event lasts, then for the selected release delay
// - reset output is low from power-up onward
// - at power-up, release follows the first delay once the regulator is up
// - a watchdog failure is a reset event too
// - undervoltage threshold is software selectable, defaulting to the first level
// - accepted soft reset returns to init mode and restores register defaults
// - select bit 0: soft reset also pulses the reset output with release delay
// - select bit 1: soft reset leaves the reset output high
// - soft reset is accepted only in normal or stop mode, else ignored
// - on release, start watchdog long open window and enter normal mode
// - power-on reset sets a flag telling all registers hold defaults
`timescale 1ns/1ps
module rso_reset_supervisor #(
    parameter int unsigned DELAY_FIRST_CYC  = rso_pkg::RESET_DELAY_FIRST_CYC,
    parameter int unsigned DELAY_SECOND_CYC = rso_pkg::RESET_DELAY_SECOND_CYC
) (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  ce_in,
    input  wire rso_pkg::rso_bus_req_t bus_req_in,
    output logic [rso_pkg::DATA_W-1:0] bus_rdata_out,
    input  wire logic                  uv_raw_in,
    input  wire logic                  wd_fail_in,
    output logic                       reset_out_n_out,
    output logic                       reset_out_n_oe_out,
    output logic [1:0]                 uv_threshold_sel_out,
    output rso_pkg::rso_dev_mode_t     dev_mode_out,
    output logic                       wd_long_window_start_out
);
    import rso_pkg::*;

    localparam logic [TIMER_W-1:0] LEN_FILTER = TIMER_W'(RESET_FILTER_CYCLES);
    localparam logic [TIMER_W-1:0] LEN_FIRST  = TIMER_W'(DELAY_FIRST_CYC);
    localparam logic [TIMER_W-1:0] LEN_SECOND = TIMER_W'(DELAY_SECOND_CYC);

    rso_main_state_t    st_q;
    rso_main_state_t    st_d;
    logic               tmr_start;
    logic               tmr_abort;
    logic [TIMER_W-1:0] tmr_len;
    logic               tmr_done;
    logic               soft_req;
    logic               soft_ok;
    logic               ctrl_wr;
    logic               stat_wr;
    logic [1:0]         wr_mode;
    logic [TIMER_W-1:0] rel_len;

    // ************************************************************
    // release and filter timer
    // ************************************************************
    rso_timer #(
        .CNT_W (TIMER_W)
    ) u_timer (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .start_in   (tmr_start),
        .abort_in   (tmr_abort),
        .len_in     (tmr_len),
        .done_out   (tmr_done)
    );

    // ************************************************************
    // bus decode
    // ************************************************************
    assign ctrl_wr  = bus_req_in.wr && (bus_req_in.addr == REG_CTRL_ADDR);
    assign stat_wr  = bus_req_in.wr && (bus_req_in.addr == REG_STATUS_ADDR);
    assign wr_mode  = bus_req_in.wdata[CTRL_MODE_LSB +: 2];
    assign soft_req = ctrl_wr && (wr_mode == MODE_CODE_SOFTRST);
    assign soft_ok  = soft_req && ((st_q.mode == DEV_NORMAL) ||
                                   (st_q.mode == DEV_STOP));
    assign rel_len  = st_q.dly_sel ? LEN_SECOND : LEN_FIRST;

    function automatic logic [1:0] mode_code(input rso_dev_mode_t m);
        logic [1:0] c;
        c = MODE_CODE_NORMAL;
        if (m == DEV_SLEEP) begin
            c = MODE_CODE_SLEEP;
        end else if (m == DEV_STOP) begin
            c = MODE_CODE_STOP;
        end
        return c;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_d          = st_q;
        tmr_start     = 1'h0;
        tmr_abort     = 1'h0;
        tmr_len       = LEN_FILTER;
        st_d.wd_start = 1'h0;
        st_d.rdata    = 8'h00;
        st_d.uv_meta  = uv_raw_in;
        st_d.uv_sync  = st_q.uv_meta;

        // register writes; an ignored soft reset leaves everything as it was
        if (ctrl_wr && !soft_req) begin
            st_d.sr_sel  = bus_req_in.wdata[CTRL_SR_SEL_BIT];
            st_d.dly_sel = bus_req_in.wdata[CTRL_DLY_SEL_BIT];
            st_d.thr_sel = bus_req_in.wdata[CTRL_THR_LSB +: 2];
            if (st_q.mode != DEV_INIT && st_q.mode != DEV_RESTART) begin
                unique case (wr_mode)
                    MODE_CODE_SLEEP: st_d.mode = DEV_SLEEP;
                    MODE_CODE_STOP:  st_d.mode = DEV_STOP;
                    default:         st_d.mode = DEV_NORMAL;
                endcase
            end
        end
        if (soft_ok) begin
            st_d.mode    = DEV_INIT;
            st_d.sr_sel  = SR_SEL_RST;
            st_d.dly_sel = DLY_SEL_RST;
            st_d.thr_sel = THR_SEL_RST;
        end
        if (stat_wr) begin
            if (bus_req_in.wdata[STAT_POR_BIT]) begin
                st_d.por_flag = 1'h0;
            end
            if (bus_req_in.wdata[STAT_WD_FAIL_BIT]) begin
                st_d.wd_fail_flag = 1'h0;
            end
        end
        // a failure in the clearing cycle is kept
        if (wd_fail_in) begin
            st_d.wd_fail_flag = 1'h1;
        end

        if (bus_req_in.rd) begin
            unique case (bus_req_in.addr)
                REG_CTRL_ADDR: begin
                    st_d.rdata[CTRL_MODE_LSB +: 2] = mode_code(st_q.mode);
                    st_d.rdata[CTRL_SR_SEL_BIT]    = st_q.sr_sel;
                    st_d.rdata[CTRL_DLY_SEL_BIT]   = st_q.dly_sel;
                    st_d.rdata[CTRL_THR_LSB +: 2]  = st_q.thr_sel;
                end
                REG_STATUS_ADDR: begin
                    st_d.rdata[STAT_POR_BIT]       = st_q.por_flag;
                    st_d.rdata[STAT_WD_FAIL_BIT]   = st_q.wd_fail_flag;
                    st_d.rdata[STAT_RST_LOW_BIT]   = ~st_q.rst_n;
                    st_d.rdata[STAT_MODE_LSB +: 5] = st_q.mode;
                end
                default: st_d.rdata = 8'h00;
            endcase
        end

        unique case (st_q.fsm)
            RS_PWRUP: begin
                if (!st_q.uv_sync) begin
                    st_d.fsm  = RS_DELAY;
                    tmr_start = 1'h1;
                    tmr_len   = LEN_FIRST;
                end
            end
            RS_RUN, RS_FILTER: begin
                if (wd_fail_in || (soft_ok && !st_q.sr_sel)) begin
                    st_d.fsm       = RS_DELAY;
                    st_d.rst_n     = 1'h0;
                    st_d.drive_low = 1'h1;
                    if (wd_fail_in) begin
                        st_d.mode = DEV_RESTART;
                    end
                    tmr_start = 1'h1;
                    tmr_len   = rel_len;
                end else if (st_q.fsm == RS_RUN) begin
                    if (st_q.uv_sync) begin
                        st_d.fsm  = RS_FILTER;
                        tmr_start = 1'h1;
                    end
                end else if (!st_q.uv_sync) begin
                    st_d.fsm  = RS_RUN;
                    tmr_abort = 1'h1;
                end else if (tmr_done) begin
                    st_d.fsm       = RS_HOLD;
                    st_d.rst_n     = 1'h0;
                    st_d.drive_low = 1'h1;
                    st_d.mode      = DEV_RESTART;
                end
            end
            RS_HOLD: begin
                if (!st_q.uv_sync) begin
                    st_d.fsm  = RS_DELAY;
                    tmr_start = 1'h1;
                    tmr_len   = rel_len;
                end
            end
            RS_DELAY: begin
                if (st_q.uv_sync) begin
                    st_d.fsm  = RS_HOLD;
                    tmr_abort = 1'h1;
                end else if (tmr_done) begin
                    st_d.fsm       = RS_RUN;
                    st_d.rst_n     = 1'h1;
                    st_d.drive_low = 1'h0;
                    st_d.mode      = DEV_NORMAL;
                    st_d.wd_start  = 1'h1;
                end
            end
            default: begin
                st_d.fsm = RS_PWRUP;
            end
        endcase

        if (!ce_in) begin
            st_d      = st_q;
            tmr_start = 1'h0;
            tmr_abort = 1'h0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            st_q <= MAIN_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus_rdata_out            = st_q.rdata;
    assign reset_out_n_out          = st_q.rst_n;
    assign reset_out_n_oe_out       = st_q.drive_low;
    assign uv_threshold_sel_out     = st_q.thr_sel;
    assign dev_mode_out             = st_q.mode;
    assign wd_long_window_start_out = st_q.wd_start;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_release;
        $rose(st_q.rst_n);
    endsequence

    sequence s_soft_pulse;
        soft_ok && ce_in && !st_q.sr_sel &&
        (st_q.fsm == RS_RUN || st_q.fsm == RS_FILTER) && !wd_fail_in;
    endsequence

    a_filter_then_low: assert property (
        ($fell(st_q.rst_n) && st_q.fsm == RS_HOLD) |->
            ($past(st_q.fsm) == RS_FILTER && $past(tmr_done) && $past(st_q.uv_sync)))
        else $error("reset asserted before filter time");

    a_hold_while_event: assert property (
        (st_q.fsm == RS_HOLD && st_q.uv_sync) |=> (!st_q.rst_n && st_q.fsm == RS_HOLD))
        else $error("reset left hold while event present");

    a_release_after_delay: assert property (
        s_release |-> ($past(tmr_done) && $past(st_q.fsm) == RS_DELAY))
        else $error("reset released without delay expiry");

    a_low_after_por: assert property (
        $past(rst_in) |-> (!st_q.rst_n && st_q.drive_low && st_q.fsm == RS_PWRUP))
        else $error("reset output not low after power-up");

    a_powerup_first_delay: assert property (
        (st_q.fsm == RS_PWRUP && !st_q.uv_sync && ce_in) |->
            (tmr_start && tmr_len == LEN_FIRST) ##1 (st_q.fsm == RS_DELAY))
        else $error("power-up release not timed by first delay");

    a_wd_fail_reset: assert property (
        (wd_fail_in && ce_in && st_q.fsm == RS_RUN) |=>
            (!st_q.rst_n && st_q.mode == DEV_RESTART && st_q.wd_fail_flag))
        else $error("watchdog failure did not assert reset");

    a_thr_default: assert property (
        $past(rst_in) |-> (uv_threshold_sel_out == THR_SEL_RST))
        else $error("threshold select not at default");

    a_soft_defaults: assert property (
        (soft_ok && ce_in) |=>
            (st_q.thr_sel == THR_SEL_RST && st_q.sr_sel == SR_SEL_RST &&
             st_q.dly_sel == DLY_SEL_RST && st_q.mode != DEV_NORMAL))
        else $error("soft reset did not restore defaults");

    a_soft_pulse_low: assert property (
        s_soft_pulse |=> (!st_q.rst_n && (st_q.fsm == RS_DELAY || st_q.fsm == RS_HOLD)) [*2])
        else $error("soft reset did not pulse reset output");

    a_soft_silent: assert property (
        (soft_ok && ce_in && st_q.sr_sel && st_q.rst_n && !wd_fail_in &&
         st_q.fsm == RS_RUN && !st_q.uv_sync) |=> (st_q.rst_n && st_q.mode == DEV_INIT))
        else $error("silent soft reset touched reset output");

    a_soft_ignored: assert property (
        (soft_req && ce_in && st_q.mode == DEV_SLEEP && !wd_fail_in && st_q.fsm == RS_RUN) |=>
            ($stable(st_q.thr_sel) && $stable(st_q.sr_sel) && st_q.mode == DEV_SLEEP))
        else $error("soft reset taken outside normal or stop mode");

    a_release_normal: assert property (
        s_release |-> (st_q.mode == DEV_NORMAL && wd_long_window_start_out)
            ##1 !wd_long_window_start_out)
        else $error("release did not start watchdog in normal mode");

    a_por_flag_set: assert property (
        $past(rst_in) |-> st_q.por_flag)
        else $error("power-on flag not set");

endmodule

// File: verif/rso_host_model.sv
// host controller model issuing register cycles to the reset supervisor
`timescale 1ns/1ps
module rso_host_model (
    input  wire logic                  ref_clk_in,
    input  wire logic [rso_pkg::DATA_W-1:0] bus_rdata_in,
    input  wire logic                  reset_out_n_in,
    output rso_pkg::rso_bus_req_t      bus_req_out
);
    import rso_pkg::*;

    initial bus_req_out = '0;

    // ************************************************************
    // register cycles
    // ************************************************************
    task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk_in);
        bus_req_out <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge ref_clk_in);
        bus_req_out <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge ref_clk_in);
        bus_req_out <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge ref_clk_in);
        bus_req_out <= '0;
        #1;
        d = bus_rdata_in;
    endtask

    // control byte with the mode field forced to the soft reset code
    task automatic soft_reset(input logic [DATA_W-1:0] d);
        write_reg(REG_CTRL_ADDR, {d[7:2], MODE_CODE_SOFTRST});
    endtask

    // settings may have fallen back to defaults, so read them again once out of reset
    task automatic recheck_ctrl(output logic [DATA_W-1:0] d);
        for (int i = 0; i < 100 && reset_out_n_in !== 1'h1; i++) begin
            @(posedge ref_clk_in);
        end
        read_reg(REG_CTRL_ADDR, d);
    endtask
endmodule

// File: verif/testbench.sv
// self-checking bench for the reset supervisor
`timescale 1ns/1ps
module testbench;
    import rso_pkg::*;
    localparam int D1 = 20;
    localparam int D2 = 10;
    localparam int FC = RESET_FILTER_CYCLES;

    logic              ref_clk_in = 1'h0;
    logic              rst_in     = 1'h1;
    logic              ce_in      = 1'h1;
    logic              uv_raw_in  = 1'h0;
    logic              wd_fail_in = 1'h0;
    rso_bus_req_t      bus_req;
    logic [DATA_W-1:0] rdata;
    logic              reset_n;
    logic              reset_oe;
    logic              wd_start;
    logic [1:0]        thr_sel;
    rso_dev_mode_t     dev_mode;
    logic [DATA_W-1:0] rd_val;
    int                err_total = 0;
    int                checked   = 0;
    int                cyc       = 0;
    int                n;

    always #10 ref_clk_in = ~ref_clk_in;

    rso_reset_supervisor #(.DELAY_FIRST_CYC(D1), .DELAY_SECOND_CYC(D2)) u_rso_reset_supervisor (
        .ref_clk_in               (ref_clk_in),
        .rst_in                   (rst_in),
        .ce_in                    (ce_in),
        .bus_req_in               (bus_req),
        .bus_rdata_out            (rdata),
        .uv_raw_in                (uv_raw_in),
        .wd_fail_in               (wd_fail_in),
        .reset_out_n_out          (reset_n),
        .reset_out_n_oe_out       (reset_oe),
        .uv_threshold_sel_out     (thr_sel),
        .dev_mode_out             (dev_mode),
        .wd_long_window_start_out (wd_start)
    );

    rso_host_model u_rso_host_model (
        .ref_clk_in     (ref_clk_in),
        .bus_rdata_in   (rdata),
        .reset_out_n_in (reset_n),
        .bus_req_out    (bus_req)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic in_range(input string what, input int v, input int lo, input int hi);
        check(what, {31'h0, v >= lo && v <= hi}, 32'h1);
    endtask

    // cycles until the reset output reaches lvl, capped at lim
    task automatic wait_level(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        #1;
        while (reset_n !== lvl && cnt < lim) begin
            @(posedge ref_clk_in);
            #1;
            cnt++;
        end
    endtask

    task automatic pulse_wd;
        @(posedge ref_clk_in);
        wd_fail_in <= 1'h1;
        @(posedge ref_clk_in);
        wd_fail_in <= 1'h0;
    endtask

    task automatic complete_run;
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        repeat (3) @(posedge ref_clk_in);
        #1;
        check("rst_low_at_start", reset_n, 1'h0);
        check("oe_at_start", reset_oe, 1'h1);
        check("thr_default", thr_sel, 2'h0);
        @(posedge ref_clk_in);
        rst_in <= 1'h0;
        wait_level(1'h1, 60, n);
        in_range("powerup_release", n, D1, D1 + 5);
        check("wd_start_at_release", wd_start, 1'h1);
        check("mode_after_release", dev_mode, DEV_NORMAL);
        check("oe_released", reset_oe, 1'h0);
        u_rso_host_model.read_reg(REG_STATUS_ADDR, rd_val);
        check("status_after_por", rd_val, 8'h11);
        u_rso_host_model.write_reg(REG_CTRL_ADDR, 8'h20);
        #1;
        check("thr_select", thr_sel, 2'h2);
        // undervoltage shorter than the filter
        @(posedge ref_clk_in);
        uv_raw_in <= 1'h1;
        repeat (400) @(posedge ref_clk_in);
        uv_raw_in <= 1'h0;
        wait_level(1'h0, 30, n);
        check("glitch_filtered", n, 30);
        // undervoltage that lasts
        @(posedge ref_clk_in);
        uv_raw_in <= 1'h1;
        wait_level(1'h0, 600, n);
        in_range("filter_time", n, FC, FC + 6);
        repeat (100) @(posedge ref_clk_in);
        check("held_during_event", reset_n, 1'h0);
        check("oe_during_event", reset_oe, 1'h1);
        uv_raw_in <= 1'h0;
        wait_level(1'h1, 60, n);
        in_range("first_delay", n, D1, D1 + 5);
        // watchdog failure with the second delay selected
        u_rso_host_model.write_reg(REG_CTRL_ADDR, 8'h08);
        pulse_wd();
        wait_level(1'h0, 4, n);
        in_range("wd_reset", n, 0, 2);
        wait_level(1'h1, 40, n);
        in_range("second_delay", n, D2, D2 + 3);
        u_rso_host_model.read_reg(REG_STATUS_ADDR, rd_val);
        check("wd_fail_flag", rd_val[STAT_WD_FAIL_BIT], 1'h1);
        u_rso_host_model.write_reg(REG_STATUS_ADDR, 8'h03);
        u_rso_host_model.read_reg(REG_STATUS_ADDR, rd_val);
        check("flags_cleared", rd_val[1:0], 2'h0);
        // soft reset pulsing the output, threshold set in the write before it
        u_rso_host_model.write_reg(REG_CTRL_ADDR, 8'h10);
        u_rso_host_model.soft_reset(8'h10);
        wait_level(1'h0, 3, n);
        in_range("soft_reset_pulse", n, 0, 1);
        check("soft_reset_mode", dev_mode, DEV_INIT);
        check("soft_reset_thr", thr_sel, 2'h0);
        wait_level(1'h1, 40, n);
        in_range("soft_reset_delay", n, D1, D1 + 3);
        check("mode_after_soft", dev_mode, DEV_NORMAL);
        u_rso_host_model.recheck_ctrl(rd_val);
        check("ctrl_defaults", rd_val, 8'h00);
        // soft reset without output pulse, then a refused one in init
        // the select bit only counts once it has been written beforehand
        u_rso_host_model.write_reg(REG_CTRL_ADDR, 8'h04);
        u_rso_host_model.soft_reset(8'h04);
        #1;
        check("quiet_soft_mode", dev_mode, DEV_INIT);
        wait_level(1'h0, 30, n);
        check("quiet_soft_no_pulse", n, 30);
        u_rso_host_model.soft_reset(8'h00);
        wait_level(1'h0, 30, n);
        check("init_soft_ignored", n, 30);
        check("init_mode_kept", dev_mode, DEV_INIT);
        pulse_wd();
        wait_level(1'h0, 4, n);
        wait_level(1'h1, 40, n);
        check("normal_after_wd", dev_mode, DEV_NORMAL);
        // stop accepts soft reset, sleep refuses it
        u_rso_host_model.write_reg(REG_CTRL_ADDR, 8'h02);
        #1;
        check("stop_mode", dev_mode, DEV_STOP);
        u_rso_host_model.soft_reset(8'h00);
        wait_level(1'h0, 3, n);
        in_range("stop_soft_taken", n, 0, 1);
        // a frozen clock enable stretches the release delay by the frozen cycles
        @(posedge ref_clk_in);
        ce_in <= 1'h0;
        repeat (5) @(posedge ref_clk_in);
        ce_in <= 1'h1;
        wait_level(1'h1, 40, n);
        check("ce_freeze_delay", n, D1);
        u_rso_host_model.write_reg(REG_CTRL_ADDR, 8'h01);
        #1;
        check("sleep_mode", dev_mode, DEV_SLEEP);
        u_rso_host_model.soft_reset(8'h00);
        wait_level(1'h0, 30, n);
        check("sleep_soft_ignored", n, 30);
        check("sleep_mode_kept", dev_mode, DEV_SLEEP);
        // reset again in mid-run
        @(posedge ref_clk_in);
        rst_in <= 1'h1;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'h0;
        #1;
        check("rst_low_midrun", reset_n, 1'h0);
        wait_level(1'h1, 60, n);
        in_range("midrun_release", n, D1, D1 + 5);
        u_rso_host_model.read_reg(REG_STATUS_ADDR, rd_val);
        check("status_after_midrun", rd_val, 8'h11);
        complete_run();
    end
endmodule
